/* File: include/irx_pkg.sv */
package irx_pkg;
  // register byte offsets
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_COUNT    = 12'h004;
  localparam logic [11:0] REG_BASE     = 12'h008;
  localparam logic [11:0] REG_STATUS   = 12'h00C;
  localparam logic [3:0]  RAM_WIN_PAGE = 4'h1;    // ram window at 0x100
  // control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_FMT_LSB   = 1;
  // status fields
  localparam int STAT_RUN_BIT   = 0;
  localparam int STAT_LEN_BIT   = 1;
  localparam int STAT_REN_BIT   = 2;
  localparam int STAT_DONE_BIT  = 3;
  localparam int STAT_WORDS_LSB = 16;
  // data formats
  localparam logic [1:0] FMT_STANDARD = 2'h0;
  localparam logic [1:0] FMT_BACKWARD = 2'h1;
  localparam logic [1:0] FMT_FORWARD  = 2'h2;
  // select-to-word-select phase values, in timer ticks
  localparam logic [15:0] PHASE_STANDARD = 16'h0003;
  localparam logic [15:0] PHASE_BACKWARD = 16'h0001;
  localparam logic [15:0] PHASE_FORWARD  = 16'h001F;
  // word geometry
  localparam int          WORD_BITS  = 32;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  // timer: four ticks per serial clock, 256 per frame
  localparam int SCK_TICK_BIT = 1;
  localparam int WS_TICK_BIT  = 7;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCK_PERIOD_NS = 160;
  localparam int TICK_DIV = SCK_PERIOD_NS / CLK_PERIOD_NS / 4;
endpackage : irx_pkg

/* File: rtl/irx_serial_unit.sv */
`timescale 1ns/10ps
// one receive-only serial slave unit
module irx_serial_unit #(
  parameter bit SEL_ACTIVE_HIGH = 1'b0  // select polarity
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        enable_i,  // unit enable bit
  input  wire logic        sck_i,     // synchronised serial clock
  input  wire logic        sd_i,      // synchronised serial data
  input  wire logic        sel_i,     // synchronised unit select
  output logic [31:0]      word_o,    // last complete word
  output logic             full_o     // buffer-full pulse
);
  typedef struct packed {
    logic        sck_prev;  // for edge detect
    logic [31:0] shift;     // incoming bits
    logic [5:0]  cnt;       // bits taken so far
    logic [31:0] word;      // receive buffer
    logic        full;      // one-cycle event
  } irx_unit_state_t;

  irx_unit_state_t st;
  irx_unit_state_t next_st;
  logic            active;

  // active only while enabled and selected at the right level
  assign active = enable_i && (sel_i == SEL_ACTIVE_HIGH);

  // next-state logic
  always_comb begin
    next_st = st;
    next_st.sck_prev = sck_i;
    next_st.full = 1'b0;
    if (!active) begin
      // a switch or disable restarts the word from its first bit
      next_st.cnt = 6'h00;
    end else if (sck_i && !st.sck_prev) begin
      next_st.shift = {st.shift[30:0], sd_i};
      if (st.cnt == 6'(irx_pkg::WORD_BITS - 1)) begin
        next_st.word = {st.shift[30:0], sd_i};
        next_st.full = 1'b1;
        next_st.cnt = 6'h00;
      end else begin
        next_st.cnt = st.cnt + 6'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign word_o = st.word;
  assign full_o = st.full;
endmodule : irx_serial_unit

/* File: rtl/irx_receiver.sv */
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/10ps
// receive path: select timer, two serial units, transfer controller
module irx_receiver #(
  parameter int RAM_AW   = 6,                  // ram words = 2**RAM_AW
  parameter int TICK_DIV = irx_pkg::TICK_DIV   // clocks per timer tick
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [11:0] addr_i,     // register byte address
  input  wire logic [31:0] wr_data_i,  // write data
  input  wire logic        wr_i,       // write strobe
  input  wire logic        rd_i,       // read strobe
  output logic [31:0]      rd_data_o,  // read data, one cycle later
  input  wire logic        sck_in_i,   // serial clock pin into units
  input  wire logic        sd_i,       // serial data pin
  input  wire logic        sel_in_i,   // unit select pin into units
  output logic             sck_o,      // timer serial clock out
  output logic             ws_o,       // timer word select out
  output logic             sel_o,      // timer unit select out
  output logic             done_o      // both units stopped
);
  // transfer controller steps, one cycle each except ST_IDLE, which waits for a request
  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_L_DATA = 9'h002,
    ST_L_ADDR = 9'h004,
    ST_R_DATA = 9'h008,
    ST_R_ADDR = 9'h010,
    ST_L_DIS  = 9'h020,
    ST_L_ENA  = 9'h040,
    ST_R_DIS  = 9'h080,
    ST_R_ENA  = 9'h100
  } irx_step_t;

  typedef struct packed {
    irx_step_t   step;      // controller step
    logic [2:0]  sck_s;     // sck sync (0,1) and spare
    logic [1:0]  sd_s;      // data sync
    logic [1:0]  sel_s;     // select sync
    logic [7:0]  div;       // tick divider
    logic [7:0]  tick;      // timer count
    logic        run;       // timer running
    logic [1:0]  fmt;       // data format
    logic [15:0] n_words;   // left channel words; the right channel takes one more
    logic [31:0] base;      // ram start byte address
    logic [31:0] dst_l;     // left destination descriptor
    logic [31:0] dst_r;     // right destination descriptor
    logic [15:0] cnt_l;     // left enable transfer counter
    logic [15:0] cnt_r;     // right enable transfer counter
    logic        chain_l;   // left disable chain enable
    logic        chain_r;   // right disable chain enable
    logic        en_l;      // left unit enable bit
    logic        en_r;      // right unit enable bit
    logic [3:0]  pend;      // l_full, r_full, l_cm, r_cm
    logic [15:0] stored;    // words written to ram
    logic        done;      // reception ended
    logic        sck;       // output regs
    logic        ws;
    logic        sel;
    logic [31:0] rd_data;
  } irx_state_t;

  localparam int P_LFULL = 0;
  localparam int P_RFULL = 1;
  localparam int P_LCM   = 2;
  localparam int P_RCM   = 3;

  irx_state_t        st;
  irx_state_t        next_st;
  logic [31:0]       ram [0:(2**RAM_AW)-1];  // receive buffer
  logic              ram_we;
  logic [RAM_AW-1:0] ram_waddr;
  logic [31:0]       ram_wdata;
  logic [31:0]       word_l;
  logic [31:0]       word_r;
  logic              full_l;
  logic              full_r;
  logic [7:0]        phase;
  logic [7:0]        next_tick;
  logic              next_sel;
  logic [3:0]        events;

  // left unit: active while select is low
  irx_serial_unit #(
    .SEL_ACTIVE_HIGH (1'b0)
  ) u_left_serial_unit (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .enable_i (st.en_l),
    .sck_i    (st.sck_s[1]),
    .sd_i     (st.sd_s[1]),
    .sel_i    (st.sel_s[1]),
    .word_o   (word_l),
    .full_o   (full_l)
  );

  // right unit: same data, active while select is high
  irx_serial_unit #(
    .SEL_ACTIVE_HIGH (1'b1)
  ) u_right_serial_unit (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .enable_i (st.en_r),
    .sck_i    (st.sck_s[1]),
    .sd_i     (st.sd_s[1]),
    .sel_i    (st.sel_s[1]),
    .word_o   (word_r),
    .full_o   (full_r)
  );

  // phase lag chosen by format
  always_comb begin
    unique case (st.fmt)
      irx_pkg::FMT_BACKWARD: phase = irx_pkg::PHASE_BACKWARD[7:0];
      irx_pkg::FMT_FORWARD:  phase = irx_pkg::PHASE_FORWARD[7:0];
      default:               phase = irx_pkg::PHASE_STANDARD[7:0];
    endcase
  end

  // timer tick, select and compare-match events
  always_comb begin
    next_tick = st.tick;
    if (st.run && st.div == 8'(TICK_DIV - 1)) begin
      next_tick = st.tick + 8'h01;
    end
    // select is word select delayed by the phase value; below the
    // phase the old level holds, so a fresh start shows no false rise
    if (next_tick < phase) begin
      next_sel = st.run && st.sel;
    end else begin
      next_sel = st.run && (8'(next_tick - phase) >= 8'h80);
    end
    events = 4'h0;
    events[P_LFULL] = full_l;
    events[P_RFULL] = full_r;
    events[P_LCM] = next_sel && !st.sel;
    events[P_RCM] = !next_sel && st.sel;
  end

  // main next-state logic
  always_comb begin
    next_st = st;
    ram_we = 1'b0;
    ram_waddr = st.dst_l[RAM_AW+1:2];
    ram_wdata = word_l;
    // pin synchronisers: first stage read only by the second
    next_st.sck_s = {1'b0, st.sck_s[0], sck_in_i};
    next_st.sd_s = {st.sd_s[0], sd_i};
    next_st.sel_s = {st.sel_s[0], sel_in_i};
    // timer
    next_st.div = (st.run && st.div != 8'(TICK_DIV - 1)) ?
                  st.div + 8'h01 : 8'h00;
    next_st.tick = next_tick;
    next_st.sck = st.run && next_tick[irx_pkg::SCK_TICK_BIT];
    next_st.ws = st.run && next_tick[irx_pkg::WS_TICK_BIT];
    next_st.sel = next_sel;
    next_st.rd_data = 32'h0000_0000;
    // controller: serve one pending request per idle cycle
    unique case (st.step)
      ST_IDLE: begin
        if (st.pend[P_LFULL]) begin
          next_st.pend[P_LFULL] = 1'b0;
          next_st.step = ST_L_DATA;
        end else if (st.pend[P_RFULL]) begin
          next_st.pend[P_RFULL] = 1'b0;
          next_st.step = ST_R_DATA;
        end else if (st.pend[P_LCM]) begin
          next_st.pend[P_LCM] = 1'b0;
          next_st.step = ST_L_DIS;
        end else if (st.pend[P_RCM]) begin
          next_st.pend[P_RCM] = 1'b0;
          next_st.step = ST_R_DIS;
        end
      end
      ST_L_DATA: begin
        // move left word, advance its destination
        ram_we = 1'b1;
        next_st.dst_l = st.dst_l + irx_pkg::WORD_BYTES;
        next_st.stored = st.stored + 16'h0001;
        next_st.step = ST_L_ADDR;
      end
      ST_L_ADDR: begin
        // hand the advanced address to the right descriptor
        next_st.dst_r = st.dst_l;
        next_st.step = ST_IDLE;
      end
      ST_R_DATA: begin
        ram_waddr = st.dst_r[RAM_AW+1:2];
        ram_wdata = word_r;
        ram_we = 1'b1;
        next_st.dst_r = st.dst_r + irx_pkg::WORD_BYTES;
        next_st.stored = st.stored + 16'h0001;
        next_st.step = ST_R_ADDR;
      end
      ST_R_ADDR: begin
        next_st.dst_l = st.dst_r;
        next_st.step = ST_IDLE;
      end
      ST_L_DIS: begin
        next_st.en_l = 1'b0;
        next_st.step = st.chain_l ? ST_L_ENA : ST_IDLE;
      end
      ST_L_ENA: begin
        next_st.en_l = 1'b1;
        if (st.cnt_l != 16'h0000) begin
          next_st.cnt_l = st.cnt_l - 16'h0001;
        end
        // chain-select: end processing only when the count expires
        if (st.cnt_l == 16'h0001 || st.cnt_l == 16'h0000) begin
          next_st.chain_l = 1'b0;
        end
        next_st.step = ST_IDLE;
      end
      ST_R_DIS: begin
        next_st.en_r = 1'b0;
        next_st.step = st.chain_r ? ST_R_ENA : ST_IDLE;
      end
      ST_R_ENA: begin
        next_st.en_r = 1'b1;
        if (st.cnt_r != 16'h0000) begin
          next_st.cnt_r = st.cnt_r - 16'h0001;
        end
        if (st.cnt_r == 16'h0001 || st.cnt_r == 16'h0000) begin
          next_st.chain_r = 1'b0;
        end
        next_st.step = ST_IDLE;
      end
      default: next_st.step = ST_IDLE;
    endcase
    // new events set after the clears above, so set wins
    if (st.run) begin
      next_st.pend = next_st.pend | events;
    end
    // stop the timer once both units are off for good
    if (st.run && !st.chain_l && !st.chain_r && !st.en_l && !st.en_r
        && st.step == ST_IDLE) begin
      next_st.run = 1'b0;
      next_st.done = 1'b1;
      next_st.pend = 4'h0;
    end
    // register writes
    if (wr_i) begin
      unique case (addr_i)
        irx_pkg::REG_CTRL: begin
          next_st.fmt = wr_data_i[irx_pkg::CTRL_FMT_LSB +: 2];
          if (wr_data_i[irx_pkg::CTRL_START_BIT]) begin
            // arm descriptors and start the timer
            next_st.run = 1'b1;
            next_st.done = 1'b0;
            next_st.div = 8'h00;
            next_st.tick = 8'h00;
            next_st.sel = 1'b0;
            next_st.pend = 4'h0;
            next_st.step = ST_IDLE;
            next_st.dst_l = st.base;
            next_st.dst_r = st.base;
            next_st.cnt_l = st.n_words - 16'h0001;
            next_st.cnt_r = st.n_words;
            next_st.chain_l = 1'b1;
            next_st.chain_r = 1'b1;
            next_st.en_l = 1'b1;
            next_st.en_r = 1'b1;
            next_st.stored = 16'h0000;
          end
        end
        irx_pkg::REG_COUNT: next_st.n_words = wr_data_i[15:0];
        irx_pkg::REG_BASE:  next_st.base = wr_data_i;
        default: ;  // other addresses ignore writes
      endcase
    end
    // register reads, data valid in the following cycle only
    if (rd_i) begin
      if (addr_i[11:8] == irx_pkg::RAM_WIN_PAGE) begin
        next_st.rd_data = ram[addr_i[RAM_AW+1:2]];
      end else begin
        unique case (addr_i)
          irx_pkg::REG_CTRL:
            next_st.rd_data = {29'h0, st.fmt, 1'b0};
          irx_pkg::REG_COUNT:
            next_st.rd_data = {16'h0000, st.n_words};
          irx_pkg::REG_BASE:
            next_st.rd_data = st.base;
          irx_pkg::REG_STATUS: begin
            next_st.rd_data[irx_pkg::STAT_RUN_BIT] = st.run;
            next_st.rd_data[irx_pkg::STAT_LEN_BIT] = st.en_l;
            next_st.rd_data[irx_pkg::STAT_REN_BIT] = st.en_r;
            next_st.rd_data[irx_pkg::STAT_DONE_BIT] = st.done;
            next_st.rd_data[irx_pkg::STAT_WORDS_LSB +: 16] = st.stored;
          end
          default: next_st.rd_data = 32'h0000_0000;  // unmapped
        endcase
      end
    end
  end

  // receive buffer, written by the data steps only
  always_ff @(posedge clk_i) begin
    if (ram_we) begin
      ram[ram_waddr] <= ram_wdata;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
      st.step <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_o = st.rd_data;
  assign sck_o = st.sck;
  assign ws_o = st.ws;
  assign sel_o = st.sel;
  assign done_o = st.done;
endmodule : irx_receiver

/* File: testbench/irx_receiver_sva.sv */
`timescale 1ns/10ps
// pin-level checks of the receive path
module irx_receiver_sva #(
  parameter int TICK_DIV = 2  // clocks per timer tick
) (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [11:0] addr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rd_data_o,
  input wire logic        sck_o,
  input wire logic        ws_o,
  input wire logic        sel_o,
  input wire logic        done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic [15:0] sck_cnt;  // clocks since sck moved
  logic [15:0] ws_cnt;   // clocks since ws moved
  logic        sck_q;    // sck one clock ago
  logic        ws_q;     // ws one clock ago
  logic        sck_seen; // first edge has no history
  logic        ws_seen;  // same for ws
  // edge spacing counters; reset forgets the history
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sck_cnt  <= 16'h0000;
      ws_cnt   <= 16'h0000;
      sck_seen <= 1'b0;
      ws_seen  <= 1'b0;
    end else begin
      sck_cnt  <= (sck_o != sck_q) ? 16'h0000 : sck_cnt + 16'h0001;
      ws_cnt   <= (ws_o != ws_q) ? 16'h0000 : ws_cnt + 16'h0001;
      sck_seen <= sck_seen | (sck_o != sck_q);
      ws_seen  <= ws_seen | (ws_o != ws_q);
    end
    sck_q <= sck_o;
    ws_q  <= ws_o;
  end
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
    else $error("read data not zero outside read slot");
  AST_UNMAPPED: assert property ($past(rd_i) && $past(addr_i) == 12'h080
    |-> rd_data_o == 32'h0) else $error("unmapped read not zero");
  AST_STAT_DONE: assert property ($past(rd_i) && $past(addr_i) == 12'h00C
    |-> rd_data_o[3] == $past(done_o)) else $error("status done wrong");
  AST_SCK_HALF: assert property (sck_seen && sck_o != sck_q
    |-> sck_cnt == 16'(2*TICK_DIV-1)) else $error("sck half period wrong");
  AST_WS_HALF: assert property (ws_seen && ws_o != ws_q
    |-> ws_cnt == 16'(128*TICK_DIV-1)) else $error("ws half frame wrong");
  AST_SEL_FOLLOW: assert property ($changed(sel_o) |-> sel_o == ws_o)
    else $error("select moved away from ws");
  AST_SEL_LAG: assert property ($changed(ws_o) |-> ##[1:64] sel_o == ws_o)
    else $error("select lag too long");
  AST_DONE_HOLD: assert property ($rose(done_o) |-> done_o [*8])
    else $error("done dropped early");
  cover property ($rose(done_o));
  cover property ($rose(sel_o));
  cover property ($past(rd_i) && $past(addr_i) == 12'h080);
endmodule : irx_receiver_sva

/* File: testbench/irx_tx_model.sv */
`timescale 1ns/10ps
// audio transmitter: msb first, changes on falling sck
module irx_tx_model (
  input  wire logic sck_i, // serial clock from the block
  input  wire logic ws_i,  // word select, low is left
  output logic      sd_o   // serial data to the block
);
  logic [31:0] shift;   // outgoing bits
  logic        last_ws; // ws at previous falling edge
  logic        pend;    // ws moved, load at next edge
  logic [15:0] frame;   // pair serial number
  initial begin
    sd_o    = 1'b0;
    shift   = 32'h0;
    last_ws = 1'b1;
    pend    = 1'b0;
    frame   = 16'h0000;
  end
  // msb one bit after the ws edge; spare bits keep toggling
  always @(negedge sck_i) begin
    #1;
    if (pend) begin
      shift = ws_i ? {16'h3CA5, frame} : {16'hC35A, frame};
      frame = ws_i ? frame + 16'h0001 : frame;
    end
    sd_o    = shift[31];
    shift   = {shift[30:0], ~shift[0]};
    pend    = (ws_i != last_ws);
    last_ws = ws_i;
  end
endmodule : irx_tx_model

/* File: testbench/irx_receiver_test.sv */
`timescale 1ns/10ps
// bench for the receive path
module irx_receiver_test;
  typedef struct packed {
    logic [1:0]  fmt; // format code
    logic [15:0] ph;  // select phase in ticks
  } irx_row_t;
  localparam int TDIV = 2; // 160 ns serial clock
  logic        clk_i     = 1'b0;
  logic        reset_i   = 1'b1;
  logic [11:0] addr_i    = 12'h000;
  logic [31:0] wr_data_i = 32'h0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [31:0] rd_data_o;
  logic        sck_o, ws_o, sel_o, done_o, sd;
  logic [31:0] v;
  int          failures    = 0;
  int          check_count = 0;
  int          cyc         = 0;
  int          n;
  irx_row_t    rows [3] = '{'{2'h0, 16'h0003}, '{2'h1, 16'h0001},
                            '{2'h2, 16'h001F}};
  irx_receiver #(.RAM_AW(6), .TICK_DIV(TDIV)) irx_receiver_i (
    .clk_i, .reset_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
    .sck_in_i(sck_o), .sd_i(sd), .sel_in_i(sel_o),
    .sck_o, .ws_o, .sel_o, .done_o);
  irx_tx_model irx_tx_model_i (.sck_i(sck_o), .ws_i(ws_o), .sd_o(sd));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic do_reset;
    reset_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
    @(posedge clk_i);
  endtask : rd
  task automatic idle_chk;
    rd(irx_pkg::REG_STATUS, v);
    chk("status idle", v, 32'h0);
    chk("pins idle", {28'h0, sck_o, ws_o, sel_o, done_o}, 32'h0);
  endtask : idle_chk
  initial begin
    do_reset();
    idle_chk();
    wr(irx_pkg::REG_COUNT, 32'h3);
    wr(irx_pkg::REG_BASE, 32'h0);
    wr(irx_pkg::REG_CTRL, 32'h1);
    n = 0;
    while (done_o !== 1'b1 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    rd(irx_pkg::REG_STATUS, v);
    chk("end status", v & 32'hF, 32'h8);
    for (int k = 1; k < 3; k++) begin
      rd(12'h100 + 12'(8 * k), v);
      chk("left word", v, {16'hC35A, 16'(k)});
      rd(12'h104 + 12'(8 * k), v);
      chk("right word", v, {16'h3CA5, 16'(k)});
    end
    wr(12'h080, 32'hFFFF_FFFF);
    rd(12'h080, v);
    chk("unmapped", v, 32'h0);
    $display("reception test done");
    foreach (rows[i]) begin
      do_reset();
      wr(irx_pkg::REG_CTRL, {29'h0, rows[i].fmt, 1'b1});
      n = 0;
      while (ws_o !== 1'b1 && n < 2000) begin
        @(posedge clk_i);
        #1;
        n++;
      end
      n = 0;
      while (sel_o !== 1'b1 && n < 200) begin
        @(posedge clk_i);
        #1;
        n++;
      end
      chk("select lag", 32'(n), 32'(rows[i].ph) * 32'(TDIV));
      $display("format row %0d done", i);
    end
    do_reset();
    wr(irx_pkg::REG_CTRL, 32'h1);
    repeat (300) @(posedge clk_i);
    do_reset();
    idle_chk();
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule : irx_receiver_test
bind irx_receiver irx_receiver_sva #(.TICK_DIV(TICK_DIV)) irx_receiver_sva_i (
  .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .rd_i(rd_i),
  .rd_data_o(rd_data_o), .sck_o(sck_o), .ws_o(ws_o), .sel_o(sel_o),
  .done_o(done_o));
